/* port_rate_pkg.sv */
// Constants shared by the port enable and bit-rate generator block
package port_rate_pkg;

  // ----------------------------------------------------------------
  // Register offsets reached by vendor register requests
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_ENABLE_OFS          = 8'h03;
  localparam logic [7:0] RATE_DIVIDER_LOW_OFS     = 8'h04;
  localparam logic [7:0] RATE_DIVIDER_MID_OFS     = 8'h05;
  localparam logic [7:0] RATE_DIVIDER_HIGH_OFS    = 8'h06;
  localparam logic [7:0] SEND_STRETCH_LOW_OFS     = 8'h07;
  localparam logic [7:0] SEND_STRETCH_HIGH_OFS    = 8'h08;
  localparam logic [7:0] RECEIVE_STRETCH_LOW_OFS  = 8'h09;
  localparam logic [7:0] RECEIVE_STRETCH_HIGH_OFS = 8'h0a;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int          TX_ENABLE_BIT   = 0;
  localparam int          RX_ENABLE_BIT   = 1;
  localparam int          DIVIDER_W       = 19;
  localparam int          PATTERN_W       = 16;
  localparam int          DIVIDER_HIGH_W  = 3;
  localparam logic [1:0]  PORT_ENABLE_RST = 2'h0;
  localparam logic [18:0] DIVIDER_RST     = 19'h00000;
  localparam logic [15:0] PATTERN_RST     = 16'h0000;

  // ----------------------------------------------------------------
  // Timing: internal clock rate the divisor is meant for, in Hz
  // ----------------------------------------------------------------
  localparam int          CORE_CLOCK_HZ   = 48000000;

endpackage : port_rate_pkg

/* bit_rate_gen.sv */
// Fractional bit-rate tick generator for one direction
`timescale 1ns/1ps
`default_nettype none

module bit_rate_gen #(
  parameter int DIV_W = 19,
  parameter int PAT_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             enable_i,
  input  wire logic [DIV_W-1:0] divisor_i,
  input  wire logic [PAT_W-1:0] pattern_i,
  output logic                  tick_o
);

  localparam int SLOT_W = $clog2(PAT_W);

  logic [DIV_W-1:0]  cnt_r;
  logic [DIV_W-1:0]  cnt_nxt;
  logic [SLOT_W-1:0] slot_r;
  logic [SLOT_W-1:0] slot_nxt;
  logic              tick_r;
  logic              tick_nxt;
  logic              stretch;
  logic [DIV_W:0]    period;
  logic [DIV_W-1:0]  last;

  // ----------------------------------------------------------------
  // Period of the current bit slot
  // ----------------------------------------------------------------
  always_comb begin
    stretch = pattern_i[slot_r];
    if (divisor_i == '0) begin
      period = {{DIV_W{1'b0}}, 1'b1} + {{DIV_W{1'b0}}, stretch};
    end else begin
      period = {1'b0, divisor_i} + {{DIV_W{1'b0}}, stretch};
    end
    last = DIV_W'(period - 1'b1);
  end

  // ----------------------------------------------------------------
  // Counter, slot walk and tick
  // ----------------------------------------------------------------
  always_comb begin
    cnt_nxt  = cnt_r;
    slot_nxt = slot_r;
    tick_nxt = 1'b0;
    if (!enable_i) begin
      cnt_nxt  = '0;
      slot_nxt = '0;
    end else if (cnt_r >= last) begin
      cnt_nxt  = '0;
      slot_nxt = SLOT_W'(slot_r + 1'b1);
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt  = DIV_W'(cnt_r + 1'b1);
    end
  end

  // Registers of the generator
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r  <= '0;
      slot_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      slot_r <= slot_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

  // ----------------------------------------------------------------
  // Checking helpers: measured gap against expected slot length
  // ----------------------------------------------------------------
  logic [DIV_W:0] gap_r;
  logic [DIV_W:0] exp_r;
  logic           armed_r;
  logic [DIV_W-1:0] div_seen_r;
  logic [PAT_W-1:0] pat_seen_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_r      <= '0;
      exp_r      <= '0;
      armed_r    <= 1'b0;
      div_seen_r <= '0;
      pat_seen_r <= '0;
    end else begin
      gap_r <= (DIV_W+1)'(gap_r + 1'b1);
      if (tick_r) begin
        gap_r      <= {{DIV_W{1'b0}}, 1'b1};
        exp_r      <= period;
        armed_r    <= enable_i;
        div_seen_r <= divisor_i;
        pat_seen_r <= pattern_i;
      end else if (!enable_i || divisor_i != div_seen_r || pattern_i != pat_seen_r) begin
        armed_r <= 1'b0;
      end
    end
  end

  slot_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_r && armed_r |-> gap_r == exp_r)
    else $error("bit slot length differs from divisor plus stretch bit");

  slot_walk_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_r && enable_i |-> slot_r == SLOT_W'($past(slot_r) + 1'b1))
    else $error("stretch slot did not advance on tick");

endmodule : bit_rate_gen

`default_nettype wire

/* port_rate_ctrl.sv */
// Port enable registers and fractional bit-rate generation for one serial port
`timescale 1ns/1ps
`default_nettype none

module port_rate_ctrl (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       reg_req_i,
  input  wire logic       reg_write_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_ack_o,
  output logic            tx_enable_o,
  output logic            rx_enable_o,
  output logic            tx_tick_o,
  output logic            rx_tick_o
);

  localparam int DW = port_rate_pkg::DIVIDER_W;
  localparam int PW = port_rate_pkg::PATTERN_W;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [1:0]    port_enable_r;
  logic [1:0]    port_enable_nxt;
  logic [DW-1:0] rate_divider_r;
  logic [DW-1:0] rate_divider_nxt;
  logic [PW-1:0] send_stretch_r;
  logic [PW-1:0] send_stretch_nxt;
  logic [PW-1:0] receive_stretch_r;
  logic [PW-1:0] receive_stretch_nxt;
  logic [7:0]    rdata_r;
  logic [7:0]    rdata_nxt;
  logic          ack_r;
  logic          ack_nxt;
  logic          wr;
  logic          rd;

  // ----------------------------------------------------------------
  // Vendor register write and read decode
  // ----------------------------------------------------------------
  always_comb begin
    wr                  = reg_req_i && reg_write_i;
    rd                  = reg_req_i && !reg_write_i;
    port_enable_nxt     = port_enable_r;
    rate_divider_nxt    = rate_divider_r;
    send_stretch_nxt    = send_stretch_r;
    receive_stretch_nxt = receive_stretch_r;
    rdata_nxt           = rdata_r;
    ack_nxt             = reg_req_i;
    if (wr) begin
      case (reg_addr_i)
        port_rate_pkg::PORT_ENABLE_OFS: begin
          port_enable_nxt = reg_wdata_i[1:0];
        end
        port_rate_pkg::RATE_DIVIDER_LOW_OFS: begin
          rate_divider_nxt[7:0] = reg_wdata_i;
        end
        port_rate_pkg::RATE_DIVIDER_MID_OFS: begin
          rate_divider_nxt[15:8] = reg_wdata_i;
        end
        port_rate_pkg::RATE_DIVIDER_HIGH_OFS: begin
          rate_divider_nxt[18:16] = reg_wdata_i[2:0];
        end
        port_rate_pkg::SEND_STRETCH_LOW_OFS: begin
          send_stretch_nxt[7:0] = reg_wdata_i;
        end
        port_rate_pkg::SEND_STRETCH_HIGH_OFS: begin
          send_stretch_nxt[15:8] = reg_wdata_i;
        end
        port_rate_pkg::RECEIVE_STRETCH_LOW_OFS: begin
          receive_stretch_nxt[7:0] = reg_wdata_i;
        end
        port_rate_pkg::RECEIVE_STRETCH_HIGH_OFS: begin
          receive_stretch_nxt[15:8] = reg_wdata_i;
        end
        default: begin
        end
      endcase
    end
    if (rd) begin
      case (reg_addr_i)
        port_rate_pkg::PORT_ENABLE_OFS:          rdata_nxt = {6'h00, port_enable_r};
        port_rate_pkg::RATE_DIVIDER_LOW_OFS:     rdata_nxt = rate_divider_r[7:0];
        port_rate_pkg::RATE_DIVIDER_MID_OFS:     rdata_nxt = rate_divider_r[15:8];
        port_rate_pkg::RATE_DIVIDER_HIGH_OFS:    rdata_nxt = {5'h00, rate_divider_r[18:16]};
        port_rate_pkg::SEND_STRETCH_LOW_OFS:     rdata_nxt = send_stretch_r[7:0];
        port_rate_pkg::SEND_STRETCH_HIGH_OFS:    rdata_nxt = send_stretch_r[15:8];
        port_rate_pkg::RECEIVE_STRETCH_LOW_OFS:  rdata_nxt = receive_stretch_r[7:0];
        port_rate_pkg::RECEIVE_STRETCH_HIGH_OFS: rdata_nxt = receive_stretch_r[15:8];
        default:                                 rdata_nxt = 8'h00;
      endcase
    end
  end

  // Register file with all-zero reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_enable_r     <= port_rate_pkg::PORT_ENABLE_RST;
      rate_divider_r    <= port_rate_pkg::DIVIDER_RST;
      send_stretch_r    <= port_rate_pkg::PATTERN_RST;
      receive_stretch_r <= port_rate_pkg::PATTERN_RST;
      rdata_r           <= 8'h00;
      ack_r             <= 1'b0;
    end else begin
      port_enable_r     <= port_enable_nxt;
      rate_divider_r    <= rate_divider_nxt;
      send_stretch_r    <= send_stretch_nxt;
      receive_stretch_r <= receive_stretch_nxt;
      rdata_r           <= rdata_nxt;
      ack_r             <= ack_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from registers
  // ----------------------------------------------------------------
  assign reg_rdata_o = rdata_r;
  assign reg_ack_o   = ack_r;
  assign tx_enable_o = port_enable_r[port_rate_pkg::TX_ENABLE_BIT];
  assign rx_enable_o = port_enable_r[port_rate_pkg::RX_ENABLE_BIT];

  // ----------------------------------------------------------------
  // Per-direction tick generators
  // ----------------------------------------------------------------
  bit_rate_gen #(.DIV_W(DW), .PAT_W(PW)) tx_gen (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .enable_i  (port_enable_r[port_rate_pkg::TX_ENABLE_BIT]),
    .divisor_i (rate_divider_r),
    .pattern_i (send_stretch_r),
    .tick_o    (tx_tick_o)
  );

  bit_rate_gen #(.DIV_W(DW), .PAT_W(PW)) rx_gen (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .enable_i  (port_enable_r[port_rate_pkg::RX_ENABLE_BIT]),
    .divisor_i (rate_divider_r),
    .pattern_i (receive_stretch_r),
    .tick_o    (rx_tick_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  reset_zero_a: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |-> !tx_enable_o && !rx_enable_o && rate_divider_r == '0
      && send_stretch_r == '0 && receive_stretch_r == '0)
    else $error("register not zero after reset");

  tx_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !tx_enable_o |=> !tx_tick_o)
    else $error("transmit tick while transmitter disabled");

  rx_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rx_enable_o |=> !rx_tick_o)
    else $error("receive tick while receiver disabled");

  enable_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && reg_addr_i == port_rate_pkg::PORT_ENABLE_OFS
      |=> tx_enable_o == $past(reg_wdata_i[0]) && rx_enable_o == $past(reg_wdata_i[1]))
    else $error("port enable write not applied");

  div_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && reg_addr_i == port_rate_pkg::RATE_DIVIDER_LOW_OFS
      |=> rate_divider_r[7:0] == $past(reg_wdata_i) && $stable(rate_divider_r[18:8]))
    else $error("divisor low byte write wrong");

  div_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && reg_addr_i == port_rate_pkg::RATE_DIVIDER_HIGH_OFS
      |=> rate_divider_r[18:16] == $past(reg_wdata_i[2:0]) && $stable(rate_divider_r[15:0]))
    else $error("divisor top byte write wrong");

  // Top divisor byte reads back three live bits over zeroed reserved bits
  top_byte_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && reg_addr_i == port_rate_pkg::RATE_DIVIDER_HIGH_OFS
      |=> reg_rdata_o[7:3] == 5'h00 && reg_rdata_o[2:0] == $past(rate_divider_r[18:16]))
    else $error("divisor top byte read wrong");

  req_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_req_i |=> reg_ack_o ##1 (reg_ack_o == $past(reg_req_i)))
    else $error("register request not acknowledged next cycle");

  unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && (reg_addr_i < port_rate_pkg::PORT_ENABLE_OFS
      || reg_addr_i > port_rate_pkg::RECEIVE_STRETCH_HIGH_OFS) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");

  tx_run_c: cover property (@(posedge clk_i) disable iff (rst_i)
    tx_enable_o && tx_tick_o ##[1:300] tx_tick_o);
  rx_run_c: cover property (@(posedge clk_i) disable iff (rst_i)
    rx_enable_o && rx_tick_o && receive_stretch_r != '0);
  readback_c: cover property (@(posedge clk_i) disable iff (rst_i)
    wr ##1 rd ##1 reg_ack_o);

endmodule : port_rate_ctrl

`default_nettype wire

/* host_model.sv */
// Host software model issuing vendor register requests to the port block
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic       clk_i,
  input  wire logic       reg_ack_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic            reg_req_o,
  output logic            reg_write_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o
);
  // Request lines idle at time zero
  initial begin
    reg_req_o   = 1'b0;
    reg_write_o = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // One request pulse, then a bounded wait for the acknowledge
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic ok);
    int n;
    ok    = 1'b0;
    rdata = 8'h00;
    @(negedge clk_i);
    reg_req_o   = 1'b1;
    reg_write_o = wr;
    reg_addr_o  = addr;
    reg_wdata_o = wdata;
    for (n = 0; n < 4 && !ok; n++) begin
      @(negedge clk_i);
      reg_req_o   = 1'b0;
      reg_addr_o  = ~addr;  // Released lines show the inverse value
      reg_wdata_o = ~wdata;
      if (reg_ack_i === 1'b1) begin
        ok    = 1'b1;
        rdata = reg_rdata_i;
      end
    end
  endtask : access

  // Loads divisor and both stretch patterns for a bit rate
  task automatic program_rate(input int rate, input logic [15:0] tx_pat,
                              input logic [15:0] rx_even, input logic [15:0] rx_odd,
                              output logic [18:0] div, output int idx, output logic ok);
    logic [15:0] rx_pat;
    logic [7:0]  val [7];
    logic [7:0]  rd;
    logic        one_ok;
    ok  = 1'b1;
    div = 19'(port_rate_pkg::CORE_CLOCK_HZ / rate);
    idx = int'((longint'(port_rate_pkg::CORE_CLOCK_HZ) * 32) / rate - longint'(div) * 32);
    rx_pat = div[0] ? rx_odd : rx_even;
    val = '{div[7:0], div[15:8], {5'h00, div[18:16]},
            tx_pat[7:0], tx_pat[15:8], rx_pat[7:0], rx_pat[15:8]};
    for (int i = 0; i < 7; i++) begin
      access(1'b1, port_rate_pkg::RATE_DIVIDER_LOW_OFS + 8'(i), val[i], rd, one_ok);
      ok = ok & one_ok;
    end
  endtask : program_rate
endmodule : host_model
`default_nettype wire

/* tb_top.sv */
// Self-checking testbench for the port enable and bit-rate block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       req;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ack;
  logic       tx_en;
  logic       rx_en;
  logic       tx_tick;
  logic       rx_tick;
  int         failures = 0;
  int         tests_run = 0;

  always #10 clk_i = ~clk_i;

  port_rate_ctrl port_rate_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .reg_req_i(req),
    .reg_write_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_ack_o(ack), .tx_enable_o(tx_en), .rx_enable_o(rx_en), .tx_tick_o(tx_tick),
    .rx_tick_o(rx_tick));

  host_model host_model_inst (.clk_i(clk_i), .reg_ack_i(ack), .reg_rdata_i(rdata),
    .reg_req_o(req), .reg_write_o(wr), .reg_addr_o(addr), .reg_wdata_o(wdata));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : expect_eq

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] rd;
    logic       ok;
    host_model_inst.access(1'b1, a, d, rd, ok);
    expect_eq(ok, 1'b1, "write acknowledge");
    if (!ok) final_report();
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] rd;
    logic       ok;
    host_model_inst.access(1'b0, a, 8'h00, rd, ok);
    expect_eq(ok, 1'b1, "read acknowledge");
    if (!ok) final_report();
    expect_eq(rd, exp, "read data");
  endtask : rd_chk

  // Times 17 bit slots after enabling; slot k lasts div plus pattern bit k
  task automatic measure(input logic rx, input int div, input logic [15:0] pat);
    int n;
    for (int k = 0; k < 18; k++) begin
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while ((rx ? rx_tick : tx_tick) !== 1'b1 && n < 400);
      if (n >= 400) begin
        failures++;
        $display("wrong value at %0t: no tick seen", $time);
        final_report();
      end
      if (k > 0) expect_eq(n, div + pat[k % 16], "slot length");
    end
  endtask : measure

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_values;
    for (int a = 3; a <= 10; a++) rd_chk(8'(a), 8'h00);
    expect_eq({tx_en, rx_en, tx_tick, rx_tick}, 4'h0, "outputs after reset");
  endtask : reset_values

  task automatic register_layout;
    logic [7:0] v [8];
    v = '{8'h00, 8'h5a, 8'ha5, 8'h05, 8'h3c, 8'hc3, 8'h96, 8'h69};
    for (int i = 0; i < 8; i++) wr_reg(8'h03 + 8'(i), v[i]);
    for (int i = 0; i < 8; i++) rd_chk(8'h03 + 8'(i), v[i]);
    wr_reg(8'h0b, 8'hff);
    rd_chk(8'h0b, 8'h00);
    wr_reg(port_rate_pkg::PORT_ENABLE_OFS, 8'h02);
    expect_eq({tx_en, rx_en}, 2'b01, "receive only enable");
    wr_reg(port_rate_pkg::PORT_ENABLE_OFS, 8'h01);
    expect_eq({tx_en, rx_en}, 2'b10, "transmit only enable");
    wr_reg(port_rate_pkg::PORT_ENABLE_OFS, 8'h00);
  endtask : register_layout

  task automatic rate_run(input int rate, input logic [15:0] txp, input logic [15:0] ev,
                          input logic [15:0] od, input int exp_div, input int exp_idx);
    logic [18:0] div;
    int          idx;
    logic        ok;
    host_model_inst.program_rate(rate, txp, ev, od, div, idx, ok);
    expect_eq(ok, 1'b1, "rate load acknowledged");
    if (!ok) final_report();
    expect_eq(div, exp_div, "divisor");
    expect_eq(idx, exp_idx, "pattern index");
    wr_reg(port_rate_pkg::PORT_ENABLE_OFS, 8'h03);
    expect_eq({tx_en, rx_en}, 2'b11, "both enabled");
    fork
      measure(1'b0, exp_div, txp);
      measure(1'b1, exp_div, (exp_div % 2) ? od : ev);
    join
    wr_reg(port_rate_pkg::PORT_ENABLE_OFS, 8'h00);
    @(negedge clk_i);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_i);
      expect_eq({tx_tick, rx_tick}, 2'b00, "tick while disabled");
    end
  endtask : rate_run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    reset_values();
    register_layout();
    rate_run(3500000, 16'h076d, 16'h06da, 16'h0bb6, 13, 22);
    rate_run(460800, 16'h0208, 16'h0040, 16'h0208, 104, 5);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
